// ---- hw/apf_pkg.sv ----
// Constants for the audio port format configuration block
// Overview of operation
// - Routing field picks ADC output pin and clock port; 00, 01, 10.
// - Routing 10 puts ADC data on auxiliary pin, no receiver data anywhere.
// - DAC de-emphasis on only at 32, 44.1, 48 kHz, detected or from rate field under forced lock.
// - Forced lock disables auto-detect; rate field picks 32/44.1/48, 00 reserved.
// - Receiver de-emphasis follows stream emphasis flag at detected rate.
// - Receiver de-emphasis under forced lock uses the rate field.
// - Format field 00 left, 01 I2S, 10 right-justified; default 01.
// - ADC one-line field: 00 follow format, 01 mode 1, 10 mode 2.
// - DAC one-line field: 00 follow format, 01 mode 1, 10 mode 2.
// - Auxiliary port right-justified words: 24 bits on 0, 16 on 1.
// - Codec port right-justified words: 24 bits on 0, 16 on 1.
// - External ADC bit clock: auxiliary on 0, codec on 1, one-line only.
// - Tristate bit floats the recovered master clock output.
// - Freeze stores volume, invert, mixing writes; applied together on release.
// - Roll-off select: fast on 0, slow on 1.
// - High-pass hold keeps subtracting the offset captured at hold.
// - Master port drives divided bit and frame clocks; slave takes them in.
package apf_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [6:0] OFS_FUNC_MODE = 7'h03;
	localparam logic [6:0] OFS_IF_FMT    = 7'h04;
	localparam logic [6:0] OFS_MISC      = 7'h05;
	localparam logic [6:0] OFS_CLK_CTRL  = 7'h06;
	localparam logic [6:0] OFS_RX_MODE   = 7'h1E;
	localparam logic [6:0] OFS_STAGE_LO  = 7'h0F;
	localparam logic [6:0] OFS_STAGE_HI  = 7'h1B;
	localparam int         STAGE_N       = 13;

	// Reset values
	localparam logic [7:0] RST_FUNC_MODE = 8'h00;
	localparam logic [7:0] RST_IF_FMT    = 8'h40;
	localparam logic [7:0] RST_MISC      = 8'h00;
	localparam logic [7:0] RST_CLK_CTRL  = 8'h00;
	localparam logic [7:0] RST_RX_MODE   = 8'h00;

	// Field positions, functional mode
	localparam int FM_ROUTE_LSB = 2;
	localparam int FM_DAC_DEEMPH = 1;
	localparam int FM_RX_DEM    = 0;
	// Field positions, interface formats
	localparam int IF_DIF_LSB   = 6;
	localparam int IF_ADC_OL_LSB = 4;
	localparam int IF_DAC_OL_LSB = 2;
	localparam int IF_AUX_RJ16  = 1;
	localparam int IF_CODEC_W16  = 0;
	// Field positions, misc control
	localparam int MC_EXT_SCLK  = 7;
	localparam int MC_RECOV_HIZ = 6;
	localparam int MC_RESERVED  = 5;
	localparam int MC_FREEZE    = 4;
	localparam int MC_ROLLOFF   = 3;
	localparam int MC_HPF_HOLD  = 2;
	localparam int MC_CODEC_MS  = 1;
	localparam int MC_AUX_MS    = 0;
	// Field positions, clock control and receiver mode
	localparam int CC_FRC_LOCK  = 0;
	localparam int RX_RATE_LSB  = 4;
	localparam logic [7:0] MASK_CLK_CTRL = 8'h01;
	localparam logic [7:0] MASK_RX_MODE  = 8'h30;

	// Two-bit codes
	localparam logic [1:0] ROUTE_CODEC   = 2'h0;
	localparam logic [1:0] ROUTE_CODEC_AUXCLK = 2'h1;
	localparam logic [1:0] ROUTE_AUX     = 2'h2;
	localparam logic [1:0] DIF_LJ        = 2'h0;
	localparam logic [1:0] DIF_I2S       = 2'h1;
	localparam logic [1:0] DIF_RJ        = 2'h2;
	localparam logic [1:0] OL_DIF        = 2'h0;
	localparam logic [1:0] OL_MODE1      = 2'h1;
	localparam logic [1:0] OL_MODE2      = 2'h2;
	localparam logic [1:0] RATE_NONE     = 2'h0;

	// Three-bit serial format numbers driven to the ports
	localparam logic [2:0] FMT_LJ   = 3'h0;
	localparam logic [2:0] FMT_I2S  = 3'h1;
	localparam logic [2:0] FMT_RJ   = 3'h2;
	localparam logic [2:0] FMT_OL1  = 3'h3;
	localparam logic [2:0] FMT_OL2  = 3'h4;

	// Master clock divider timing
	localparam int SCLK_HALF_CYC = 1;
	localparam int LRCK_SCLKS    = 64;
endpackage

// ---- hw/apf_stage.sv ----
// Staged volume, invert and mixing bytes with freeze hold
`timescale 1ns/1ns
module apf_stage
	import apf_pkg::*;
#(
	parameter int N = STAGE_N
) (
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           rst,
	// Software side
	input  wire logic           wr,
	input  wire logic [3:0]     idx,
	input  wire logic [7:0]     wdata,
	input  wire logic           freeze,
	output logic      [7:0]     rd_byte,
	// Applied settings
	output logic      [N*8-1:0] live
);
	logic [7:0] shadow_q [N];

	generate
		if (N < 1 || N > 16)
			$error("apf_stage: N must be 1 to 16");
	endgenerate

	// Written value always lands in the shadow copy
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < N; i++)
				shadow_q[i] <= 8'h00;
		end
		else if (wr && idx < N)
			shadow_q[idx] <= wdata;
	end

	// Live copy follows shadow only while not frozen
	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_live
			always_ff @(posedge clk)
			begin
				if (rst)
					live[g*8 +: 8] <= 8'h00;
				else if (!freeze)
					live[g*8 +: 8] <= shadow_q[g];
			end
		end
	endgenerate

	// Read back shows the stored value
	always_comb
	begin
		rd_byte = (idx < N) ? shadow_q[idx] : 8'h00;
	end
endmodule

// ---- hw/apf_sync3.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module apf_sync3 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Asynchronous in, filtered out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// Shift chain; first stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else
		begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a change once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (rst)
			q <= '0;
		else if (s2_q == s3_q)
			q <= s3_q;
	end
endmodule

// ---- hw/apf_top.sv ----
// Audio port format and filter option register bank
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
module apf_top
	import apf_pkg::*;
#(
	parameter int DW        = 24,
	parameter int SCLK_HALF = SCLK_HALF_CYC,
	parameter int LRCK_DIV  = LRCK_SCLKS
) (
	// Clock and reset
	input  wire logic             CLOCK,
	input  wire logic             SYS_RST,
	// Register port
	input  wire logic [6:0]       ADDR,
	input  wire logic [7:0]       WDATA,
	input  wire logic             WR,
	input  wire logic             RD,
	output logic      [7:0]       RDATA,
	// Serial data sources and pins
	input  wire logic             ADC_SDATA,
	input  wire logic             RX_SDATA,
	output logic                  CODEC_SDOUT,
	output logic                  AUX_SDOUT,
	output logic                  ADC_CLK_FROM_AUX,
	// Port clock pins, codec then auxiliary
	input  wire logic             CODEC_SCLK_I,
	input  wire logic             CODEC_LRCK_I,
	output logic                  CODEC_SCLK_O,
	output logic                  CODEC_LRCK_O,
	output logic                  CODEC_CLK_OE_N,
	input  wire logic             AUX_SCLK_I,
	input  wire logic             AUX_LRCK_I,
	output logic                  AUX_SCLK_O,
	output logic                  AUX_LRCK_O,
	output logic                  AUX_CLK_OE_N,
	output logic                  EXT_ADC_SCLK,
	// Recovered master clock pin
	input  wire logic             RECOV_CLK_IN,
	output logic                  RECOV_CLK_O,
	output logic                  RECOV_CLK_OE_N,
	// Receiver status
	input  wire logic [1:0]       DET_RATE,
	input  wire logic             RX_EMPH,
	// De-emphasis controls
	output logic                  DAC_DEEMPH_EN,
	output logic      [1:0]       DAC_DEEMPH_RATE,
	output logic                  RX_DEEMPH_EN,
	output logic      [1:0]       RX_DEEMPH_RATE,
	// Format controls
	output logic      [2:0]       ADC_FMT,
	output logic      [2:0]       DAC_FMT,
	output logic      [2:0]       AUX_FMT,
	output logic                  CODEC_WORD16,
	output logic                  AUX_WORD16,
	output logic                  INTERP_SLOW,
	// Staged gain, invert and mixing
	output logic [STAGE_N*8-1:0]  STAGED_OUT,
	// ADC offset path
	input  wire logic [DW-1:0]    ADC_SAMPLE,
	input  wire logic             ADC_SAMPLE_VALID,
	input  wire logic [DW-1:0]    DC_EST,
	output logic                  HPF_DISABLE,
	output logic      [DW-1:0]    ADC_RESULT,
	output logic                  ADC_RESULT_VALID
);
	logic [7:0]    func_q;
	logic [7:0]    ifmt_q;
	logic [7:0]    misc_q;
	logic [7:0]    clkc_q;
	logic [7:0]    rxm_q;
	logic          stage_hit;
	logic [3:0]    stage_idx;
	logic [7:0]    stage_rd;
	logic [STAGE_N*8-1:0] stage_live;
	logic [1:0]    route;
	logic [1:0]    dif;
	logic          frc_lock;
	logic [1:0]    rate_sel;
	logic          oneline;
	logic [1:0]    sclk_in_s;
	logic [1:0]    lrck_in_s;
	logic          recov_s;
	logic [1:0]    sclk_int;
	logic [1:0]    lrck_int;
	logic [1:0]    master;
	logic [1:0]    port_sclk;
	logic [7:0]    rd_d;
	logic [2:0]    dac_deemph;
	logic [2:0]    rx_deemph;
	logic          hold_prev_q;
	logic [DW-1:0] held_ofs_q;

	generate
		if (DW < 2 || SCLK_HALF < 1 || LRCK_DIV < 2 || LRCK_DIV % 2 != 0)
			$error("apf_top: unsupported parameter values");
	endgenerate

	// Field views; reserved codes fall back to defaults
	always_comb
	begin
		route    = func_q[FM_ROUTE_LSB +: 2];
		if (route == 2'h3)
			route = ROUTE_CODEC;
		dif      = ifmt_q[IF_DIF_LSB +: 2];
		if (dif == 2'h3)
			dif = DIF_I2S;
		frc_lock = clkc_q[CC_FRC_LOCK];
		rate_sel = rxm_q[RX_RATE_LSB +: 2];
		oneline  = (ifmt_q[IF_ADC_OL_LSB +: 2] == OL_MODE1) || (ifmt_q[IF_ADC_OL_LSB +: 2] == OL_MODE2)
			|| (ifmt_q[IF_DAC_OL_LSB +: 2] == OL_MODE1) || (ifmt_q[IF_DAC_OL_LSB +: 2] == OL_MODE2);
		master   = {misc_q[MC_CODEC_MS], misc_q[MC_AUX_MS]};
	end

	// Staged register window decode
	always_comb
	begin
		stage_hit = (ADDR >= OFS_STAGE_LO) && (ADDR <= OFS_STAGE_HI);
		stage_idx = 4'(ADDR - OFS_STAGE_LO);
	end

	// Format number from one-line field and format field
	function automatic logic [2:0] fmt_of(input logic [1:0] ol, input logic [1:0] d);
		logic [2:0] f;
		case (d)
			DIF_LJ:  f = FMT_LJ;
			DIF_RJ:  f = FMT_RJ;
			default: f = FMT_I2S;
		endcase
		case (ol)
			OL_MODE1: f = FMT_OL1;
			OL_MODE2: f = FMT_OL2;
			default:  f = f;
		endcase
		return f;
	endfunction

	// Enable and rate for one de-emphasis path
	function automatic logic [2:0] deemph_of(input logic en, input logic frc, input logic [1:0] sel,
		input logic [1:0] det);
		logic [1:0] r;
		r = frc ? sel : det;
		if (!en || r == RATE_NONE)
			return {1'b0, RATE_NONE};
		return {1'b1, r};
	endfunction

	// Register writes
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			func_q <= RST_FUNC_MODE;
			ifmt_q <= RST_IF_FMT;
			misc_q <= RST_MISC;
			clkc_q <= RST_CLK_CTRL;
			rxm_q  <= RST_RX_MODE;
		end
		else if (WR)
		begin
			case (ADDR)
				OFS_FUNC_MODE: func_q <= WDATA;
				OFS_IF_FMT:    ifmt_q <= WDATA;
				OFS_MISC:      misc_q <= WDATA & ~(8'h01 << MC_RESERVED);
				OFS_CLK_CTRL:  clkc_q <= WDATA & MASK_CLK_CTRL;
				OFS_RX_MODE:   rxm_q  <= WDATA & MASK_RX_MODE;
				default:       ;
			endcase
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		case (ADDR)
			OFS_FUNC_MODE: rd_d = func_q;
			OFS_IF_FMT:    rd_d = ifmt_q;
			OFS_MISC:      rd_d = misc_q;
			OFS_CLK_CTRL:  rd_d = clkc_q;
			OFS_RX_MODE:   rd_d = rxm_q;
			default:       rd_d = stage_hit ? stage_rd : 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
			RDATA <= 8'h00;
		else
			RDATA <= RD ? rd_d : 8'h00;
	end

	// Staged bytes held while frozen
	apf_stage #(.N(STAGE_N)) u_stage (
		.clk     (CLOCK),
		.rst     (SYS_RST),
		.wr      (WR && stage_hit),
		.idx     (stage_idx),
		.wdata   (WDATA),
		.freeze  (misc_q[MC_FREEZE]),
		.rd_byte (stage_rd),
		.live    (stage_live)
	);

	// Applied staged settings
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
			STAGED_OUT <= '0;
		else
			STAGED_OUT <= stage_live;
	end

	// Pin clocks from outside the domain
	apf_sync3 #(.W(5)) u_sync (
		.clk (CLOCK),
		.rst (SYS_RST),
		.d   ({RECOV_CLK_IN, CODEC_LRCK_I, AUX_LRCK_I, CODEC_SCLK_I, AUX_SCLK_I}),
		.q   ({recov_s, lrck_in_s, sclk_in_s})
	);

	// Per-port master clock dividers; index 1 codec, 0 auxiliary
	genvar p;
	generate
		for (p = 0; p < 2; p++)
		begin : g_port
			logic [15:0] div_q;
			logic [15:0] bits_q;
			logic        sclk_q;
			logic        lrck_q;

			always_ff @(posedge CLOCK)
			begin
				if (SYS_RST || !master[p])
				begin
					div_q  <= 16'h0000;
					bits_q <= 16'h0000;
					sclk_q <= 1'b0;
					lrck_q <= 1'b0;
				end
				else if (div_q == 16'(SCLK_HALF - 1))
				begin
					div_q  <= 16'h0000;
					sclk_q <= ~sclk_q;
					if (sclk_q)
					begin
						if (bits_q == 16'(LRCK_DIV / 2 - 1))
						begin
							bits_q <= 16'h0000;
							lrck_q <= ~lrck_q;
						end
						else
							bits_q <= bits_q + 16'h0001;
					end
				end
				else
					div_q <= div_q + 16'h0001;
			end

			assign sclk_int[p]  = sclk_q;
			assign lrck_int[p]  = lrck_q;
			assign port_sclk[p] = master[p] ? sclk_q : sclk_in_s[p];
		end
	endgenerate

	// Port clock pins: driven as master, released as slave
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			CODEC_SCLK_O   <= 1'b0;
			CODEC_LRCK_O   <= 1'b0;
			CODEC_CLK_OE_N <= 1'b1;
			AUX_SCLK_O     <= 1'b0;
			AUX_LRCK_O     <= 1'b0;
			AUX_CLK_OE_N   <= 1'b1;
		end
		else
		begin
			CODEC_SCLK_O   <= sclk_int[1];
			CODEC_LRCK_O   <= lrck_int[1];
			CODEC_CLK_OE_N <= ~master[1];
			AUX_SCLK_O     <= sclk_int[0];
			AUX_LRCK_O     <= lrck_int[0];
			AUX_CLK_OE_N   <= ~master[0];
		end
	end

	// External ADC bit clock, only in one-line operation
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
			EXT_ADC_SCLK <= 1'b0;
		else if (!oneline)
			EXT_ADC_SCLK <= 1'b0;
		else
			EXT_ADC_SCLK <= misc_q[MC_EXT_SCLK] ? port_sclk[1] : port_sclk[0];
	end

	// ADC and receiver data routing to the two output pins
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			CODEC_SDOUT      <= 1'b0;
			AUX_SDOUT        <= 1'b0;
			ADC_CLK_FROM_AUX <= 1'b0;
		end
		else
		begin
			ADC_CLK_FROM_AUX <= (route != ROUTE_CODEC);
			if (route == ROUTE_AUX)
			begin
				CODEC_SDOUT <= 1'b0;
				AUX_SDOUT   <= ADC_SDATA;
			end
			else
			begin
				CODEC_SDOUT <= ADC_SDATA;
				AUX_SDOUT   <= RX_SDATA;
			end
		end
	end

	// Recovered clock output and its tristate
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			RECOV_CLK_O    <= 1'b0;
			RECOV_CLK_OE_N <= 1'b0;
		end
		else
		begin
			RECOV_CLK_O    <= recov_s;
			RECOV_CLK_OE_N <= misc_q[MC_RECOV_HIZ];
		end
	end

	// De-emphasis selection for DAC and receiver paths
	always_comb
	begin
		dac_deemph = deemph_of(func_q[FM_DAC_DEEMPH], frc_lock, rate_sel, DET_RATE);
		rx_deemph  = deemph_of(func_q[FM_RX_DEM] & RX_EMPH, frc_lock, rate_sel, DET_RATE);
	end

	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			DAC_DEEMPH_EN   <= 1'b0;
			DAC_DEEMPH_RATE <= RATE_NONE;
			RX_DEEMPH_EN    <= 1'b0;
			RX_DEEMPH_RATE  <= RATE_NONE;
		end
		else
		begin
			DAC_DEEMPH_EN   <= dac_deemph[2];
			DAC_DEEMPH_RATE <= dac_deemph[1:0];
			RX_DEEMPH_EN    <= rx_deemph[2];
			RX_DEEMPH_RATE  <= rx_deemph[1:0];
		end
	end

	// Serial formats, word lengths and roll-off
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			ADC_FMT      <= FMT_I2S;
			DAC_FMT      <= FMT_I2S;
			AUX_FMT      <= FMT_I2S;
			CODEC_WORD16 <= 1'b0;
			AUX_WORD16   <= 1'b0;
			INTERP_SLOW  <= 1'b0;
		end
		else
		begin
			ADC_FMT      <= fmt_of(ifmt_q[IF_ADC_OL_LSB +: 2], dif);
			DAC_FMT      <= fmt_of(ifmt_q[IF_DAC_OL_LSB +: 2], dif);
			AUX_FMT      <= fmt_of(OL_DIF, dif);
			CODEC_WORD16 <= ifmt_q[IF_CODEC_W16];
			AUX_WORD16   <= ifmt_q[IF_AUX_RJ16];
			INTERP_SLOW  <= misc_q[MC_ROLLOFF];
		end
	end

	// Offset capture at the moment hold is set
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			hold_prev_q <= 1'b0;
			held_ofs_q  <= '0;
			HPF_DISABLE <= 1'b0;
		end
		else
		begin
			hold_prev_q <= misc_q[MC_HPF_HOLD];
			HPF_DISABLE <= misc_q[MC_HPF_HOLD];
			if (misc_q[MC_HPF_HOLD] && !hold_prev_q)
				held_ofs_q <= DC_EST;
		end
	end

	// Offset-corrected conversion results
	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			ADC_RESULT       <= '0;
			ADC_RESULT_VALID <= 1'b0;
		end
		else
		begin
			ADC_RESULT_VALID <= ADC_SAMPLE_VALID;
			if (ADC_SAMPLE_VALID)
				ADC_RESULT <= ADC_SAMPLE - (hold_prev_q ? held_ofs_q : DC_EST);
		end
	end
endmodule

// ---- testbench/apf_monitor.sv ----
// Port-level checks for the audio port format block
`timescale 1ns/1ns
module apf_mon
	import apf_pkg::*;
#(
	parameter int DW = 24
) (
	// Clock and reset
	input wire logic          CLOCK,
	input wire logic          SYS_RST,
	// Register port
	input wire logic [6:0]    ADDR,
	input wire logic [7:0]    WDATA,
	input wire logic          WR,
	input wire logic          RD,
	input wire logic [7:0]    RDATA,
	// Controls from the block
	input wire logic          RECOV_CLK_OE_N,
	input wire logic          INTERP_SLOW,
	input wire logic          CODEC_WORD16,
	input wire logic          AUX_WORD16,
	input wire logic          CODEC_CLK_OE_N,
	input wire logic          CODEC_SCLK_O,
	input wire logic          CODEC_LRCK_O,
	input wire logic [2:0]    ADC_FMT,
	input wire logic [2:0]    DAC_FMT,
	input wire logic [2:0]    AUX_FMT,
	input wire logic          DAC_DEEMPH_EN,
	input wire logic [1:0]    DAC_DEEMPH_RATE,
	input wire logic          RX_DEEMPH_EN,
	input wire logic [1:0]    RX_DEEMPH_RATE,
	// Offset path
	input wire logic [DW-1:0] ADC_SAMPLE,
	input wire logic          ADC_SAMPLE_VALID,
	input wire logic [DW-1:0] DC_EST,
	input wire logic          HPF_DISABLE,
	input wire logic [DW-1:0] ADC_RESULT
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);
	logic [7:0] wd1_q;
	logic [7:0] wd2_q;

	// Write data two cycles back, to match field latency
	always_ff @(posedge CLOCK)
	begin
		wd1_q <= WDATA;
		wd2_q <= wd1_q;
	end

	a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data not zero outside a read answer");
	a_recov_hiz: assert property (WR && ADDR == OFS_MISC |-> ##2 RECOV_CLK_OE_N == wd2_q[MC_RECOV_HIZ])
		else $error("recovered clock enable does not follow write");
	a_rolloff_sel: assert property (WR && ADDR == OFS_MISC |-> ##2 INTERP_SLOW == wd2_q[MC_ROLLOFF])
		else $error("roll-off select does not follow write");
	a_word_len: assert property (WR && ADDR == OFS_IF_FMT |-> ##2 {AUX_WORD16, CODEC_WORD16} == wd2_q[1:0])
		else $error("word length outputs do not follow write");
	a_port_drive: assert property (WR && ADDR == OFS_MISC |-> ##2 CODEC_CLK_OE_N == !wd2_q[MC_CODEC_MS])
		else $error("codec clock drive does not follow master bit");
	a_sclk_runs: assert property (!CODEC_CLK_OE_N [*4] |-> CODEC_SCLK_O != $past(CODEC_SCLK_O))
		else $error("codec bit clock not toggling in master mode");
	a_slave_quiet: assert property (CODEC_CLK_OE_N && $past(CODEC_CLK_OE_N) |-> !CODEC_SCLK_O && !CODEC_LRCK_O)
		else $error("codec clocks active in slave mode");
	a_fmt_legal: assert property (ADC_FMT <= FMT_OL2 && DAC_FMT <= FMT_OL2 && AUX_FMT <= FMT_RJ)
		else $error("format output outside legal codes");
	a_dem_rate: assert property (
		DAC_DEEMPH_EN == (DAC_DEEMPH_RATE != 2'h0) && RX_DEEMPH_EN == (RX_DEEMPH_RATE != 2'h0))
		else $error("de-emphasis enable and rate disagree");
	a_offset_live: assert property (ADC_SAMPLE_VALID && !HPF_DISABLE |=>
		HPF_DISABLE || ADC_RESULT == $past(ADC_SAMPLE) - $past(DC_EST))
		else $error("result is not sample minus live offset");
endmodule

bind apf_top apf_mon #(.DW(DW)) u_mon (
	.CLOCK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .RECOV_CLK_OE_N, .INTERP_SLOW, .CODEC_WORD16, .AUX_WORD16,
	.CODEC_CLK_OE_N, .CODEC_SCLK_O, .CODEC_LRCK_O, .ADC_FMT, .DAC_FMT, .AUX_FMT, .DAC_DEEMPH_EN, .DAC_DEEMPH_RATE,
	.RX_DEEMPH_EN, .RX_DEEMPH_RATE, .ADC_SAMPLE, .ADC_SAMPLE_VALID, .DC_EST, .HPF_DISABLE, .ADC_RESULT
);

// ---- testbench/apf_top_tb.sv ----
// Self-checking bench for the format and filter option registers
`timescale 1ns/1ns
module apf_top_tb
	import apf_pkg::*;
;
	// Stimulus
	logic          CLOCK = 1'b0;
	logic          SYS_RST = 1'b1;
	logic [6:0]    ADDR = 7'h00;
	logic [7:0]    WDATA = 8'h00;
	logic          WR = 1'b0, RD = 1'b0, ADC_SDATA = 1'b0, RX_SDATA = 1'b0, RX_EMPH = 1'b0;
	logic          CODEC_SCLK_I = 1'b0, AUX_SCLK_I = 1'b0, RECOV_CLK_IN = 1'b0, ADC_SAMPLE_VALID = 1'b0;
	logic [1:0]    DET_RATE = 2'h0;
	logic [23:0]   ADC_SAMPLE = 24'h000000, DC_EST = 24'h000000;
	// Observed
	logic [7:0]    RDATA;
	logic          CODEC_SDOUT, AUX_SDOUT, ADC_CLK_FROM_AUX, EXT_ADC_SCLK, RECOV_CLK_O, RECOV_CLK_OE_N;
	logic          CODEC_SCLK_O, CODEC_LRCK_O, CODEC_CLK_OE_N, AUX_SCLK_O, AUX_LRCK_O, AUX_CLK_OE_N;
	logic          DAC_DEEMPH_EN, RX_DEEMPH_EN, CODEC_WORD16, AUX_WORD16, INTERP_SLOW;
	logic          HPF_DISABLE, ADC_RESULT_VALID;
	logic [1:0]    DAC_DEEMPH_RATE, RX_DEEMPH_RATE;
	logic [2:0]    ADC_FMT, DAC_FMT, AUX_FMT;
	logic [103:0]  STAGED_OUT, va, vb;
	logic [23:0]   ADC_RESULT, d1, d2;
	logic [7:0]    m;
	logic [3:0]    p;
	logic [1:0]    fd, fa, fo;
	int            bad_count = 0, checks_done = 0, i, j;
	int            n [4];

	// Bench clock
	always #50 CLOCK = ~CLOCK;

	apf_top #(.LRCK_DIV(8)) dut (
		.CLOCK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .ADC_SDATA, .RX_SDATA, .CODEC_SDOUT, .AUX_SDOUT,
		.ADC_CLK_FROM_AUX, .CODEC_SCLK_I, .CODEC_LRCK_I(1'b0), .CODEC_SCLK_O, .CODEC_LRCK_O, .CODEC_CLK_OE_N,
		.AUX_SCLK_I, .AUX_LRCK_I(1'b0), .AUX_SCLK_O, .AUX_LRCK_O, .AUX_CLK_OE_N, .EXT_ADC_SCLK, .RECOV_CLK_IN,
		.RECOV_CLK_O, .RECOV_CLK_OE_N, .DET_RATE, .RX_EMPH, .DAC_DEEMPH_EN, .DAC_DEEMPH_RATE, .RX_DEEMPH_EN,
		.RX_DEEMPH_RATE, .ADC_FMT, .DAC_FMT, .AUX_FMT, .CODEC_WORD16, .AUX_WORD16, .INTERP_SLOW, .STAGED_OUT,
		.ADC_SAMPLE, .ADC_SAMPLE_VALID, .DC_EST, .HPF_DISABLE, .ADC_RESULT, .ADC_RESULT_VALID
	);

	// Expected values
	function automatic logic [2:0] dem(input logic on, frc, input logic [1:0] r, det);
		logic [1:0] s;
		s = frc ? r : det;
		return (on && s != 2'h0) ? {1'b1, s} : 3'h0;
	endfunction

	function automatic logic [2:0] fmt(input logic [1:0] ol, dif);
		return (ol == OL_MODE1) ? FMT_OL1 : (ol == OL_MODE2) ? FMT_OL2 : {1'b0, dif};
	endfunction

	function automatic logic [2:0] route(input logic [1:0] r, input logic a, x);
		return (r == ROUTE_AUX) ? {1'b0, a, 1'b1} : {a, x, r != ROUTE_CODEC};
	endfunction

	// Compare and bus tasks
	task automatic chk(input string nm, input logic [103:0] e, input logic [103:0] g);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		ADDR  <= a;
		WDATA <= d;
		WR    <= 1'b1;
		@(posedge CLOCK);
		WR    <= 1'b0;
		repeat (3) @(posedge CLOCK);
		#1;
	endtask

	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		@(posedge CLOCK);
		ADDR <= a;
		RD   <= 1'b1;
		@(posedge CLOCK);
		RD   <= 1'b0;
		#1;
		chk("read data", e, RDATA);
	endtask

	task automatic smp(input logic [23:0] s, input logic [23:0] d);
		@(posedge CLOCK);
		ADC_SAMPLE       <= s;
		ADC_SAMPLE_VALID <= 1'b1;
		@(posedge CLOCK);
		ADC_SAMPLE_VALID <= 1'b0;
		#1;
		chk("adc result", {1'b1, s - d}, {ADC_RESULT_VALID, ADC_RESULT});
	endtask

	task automatic stage_fill(output logic [103:0] v);
		for (int k = 0; k < 13; k++)
		begin
			v[8*k +: 8] = 8'($urandom);
			wr(OFS_STAGE_LO + 7'(k), v[8*k +: 8]);
		end
	endtask

	task automatic rst_chk;
		repeat (2) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		@(posedge CLOCK);
		#1;
		chk("reset outputs", {3'b110, FMT_I2S, FMT_I2S, FMT_I2S},
			{CODEC_CLK_OE_N, AUX_CLK_OE_N, RECOV_CLK_OE_N, ADC_FMT, DAC_FMT, AUX_FMT});
		wr(7'h40, 8'hFF);
		rdchk(7'h40, 8'h00);
		rdchk(OFS_FUNC_MODE, RST_FUNC_MODE);
		rdchk(OFS_IF_FMT, 8'h40);
		rdchk(OFS_MISC, 8'h00);
		rdchk(OFS_CLK_CTRL, 8'h00);
		rdchk(OFS_RX_MODE, 8'h00);
		$display("Test reset done");
	endtask

	task automatic end_sim;
		$display("Checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		void'($urandom(42890));
		rst_chk();
		for (i = 0; i < 16; i++)
		begin
			if (i % 4 == 0)
				wr(OFS_FUNC_MODE, {4'h0, 2'(i / 4), 2'h0});
			@(posedge CLOCK);
			ADC_SDATA <= i[0];
			RX_SDATA  <= i[1];
			repeat (3) @(posedge CLOCK);
			#1;
			chk("routing", route((i < 12) ? 2'(i / 4) : ROUTE_CODEC, i[0], i[1]),
				{CODEC_SDOUT, AUX_SDOUT, ADC_CLK_FROM_AUX});
		end
		$display("Test routing done");
		for (i = 0; i < 128; i++)
		begin
			@(posedge CLOCK);
			DET_RATE <= i[1:0];
			RX_EMPH  <= 1'($urandom);
			wr(OFS_FUNC_MODE, {6'h00, i[6:5]});
			wr(OFS_CLK_CTRL, {7'($urandom), i[4]});
			wr(OFS_RX_MODE, {2'($urandom), i[3:2], 4'($urandom)});
			chk("dac deemph", dem(i[6], i[4], i[3:2], i[1:0]), {DAC_DEEMPH_EN, DAC_DEEMPH_RATE});
			chk("rx deemph", dem(i[5] & RX_EMPH, i[4], i[3:2], i[1:0]), {RX_DEEMPH_EN, RX_DEEMPH_RATE});
			rdchk(OFS_RX_MODE, {2'h0, i[3:2], 4'h0});
			rdchk(OFS_CLK_CTRL, {7'h00, i[4]});
		end
		$display("Test de-emphasis done");
		for (i = 0; i < 36; i++)
		begin
			fd = 2'(i % 3);
			fa = 2'(i / 3 % 3);
			fo = 2'(i / 9);
			m  = {fd, fa, fo, 2'($urandom)};
			wr(OFS_IF_FMT, m);
			chk("formats", {fmt(fa, fd), fmt(fo, fd), 1'b0, fd}, {ADC_FMT, DAC_FMT, AUX_FMT});
			chk("word16", m[1:0], {AUX_WORD16, CODEC_WORD16});
			rdchk(OFS_IF_FMT, m);
		end
		$display("Test formats done");
		wr(OFS_IF_FMT, 8'h50);
		for (i = 0; i < 8; i++)
		begin
			m = {i[0], 2'($urandom), 1'b0, 1'($urandom), 3'h0};
			@(posedge CLOCK);
			AUX_SCLK_I   <= 1'($urandom);
			CODEC_SCLK_I <= 1'($urandom);
			RECOV_CLK_IN <= 1'($urandom);
			wr(OFS_MISC, m);
			repeat (3) @(posedge CLOCK);
			#1;
			chk("ext adc clock", m[7] ? CODEC_SCLK_I : AUX_SCLK_I, EXT_ADC_SCLK);
			chk("misc outputs", {m[6], m[3], RECOV_CLK_IN}, {RECOV_CLK_OE_N, INTERP_SLOW, RECOV_CLK_O});
			rdchk(OFS_MISC, m & 8'hDF);
		end
		@(posedge CLOCK);
		AUX_SCLK_I   <= 1'b1;
		CODEC_SCLK_I <= 1'b1;
		wr(OFS_IF_FMT, 8'h40);
		chk("ext clock idle", 1'b0, EXT_ADC_SCLK);
		$display("Test misc done");
		wr(OFS_MISC, 8'h03);
		n = '{0, 0, 0, 0};
		for (i = 0; i < 64; i++)
		begin
			p = {CODEC_SCLK_O, CODEC_LRCK_O, AUX_SCLK_O, AUX_LRCK_O};
			@(posedge CLOCK);
			#1;
			p = p ^ {CODEC_SCLK_O, CODEC_LRCK_O, AUX_SCLK_O, AUX_LRCK_O};
			for (j = 0; j < 4; j++)
				n[j] += p[3-j];
		end
		chk("port clocks", {8'h40, 8'h08, 8'h40, 8'h08, 2'b00},
			{8'(n[0]), 8'(n[1]), 8'(n[2]), 8'(n[3]), CODEC_CLK_OE_N, AUX_CLK_OE_N});
		wr(OFS_MISC, 8'h00);
		chk("port release", 6'b110000,
			{CODEC_CLK_OE_N, AUX_CLK_OE_N, CODEC_SCLK_O, CODEC_LRCK_O, AUX_SCLK_O, AUX_LRCK_O});
		$display("Test port clocks done");
		stage_fill(va);
		chk("staged", va, STAGED_OUT);
		wr(OFS_MISC, 8'h10);
		stage_fill(vb);
		chk("staged frozen", va, STAGED_OUT);
		for (i = 0; i < 13; i++)
			rdchk(OFS_STAGE_LO + 7'(i), vb[8*i +: 8]);
		wr(OFS_MISC, 8'h00);
		chk("staged release", vb, STAGED_OUT);
		$display("Test freeze done");
		d1 = 24'($urandom);
		d2 = 24'($urandom);
		@(posedge CLOCK);
		DC_EST <= d1;
		smp(24'($urandom), d1);
		wr(OFS_MISC, 8'h04);
		@(posedge CLOCK);
		DC_EST <= d2;
		smp(24'($urandom), d1);
		smp(24'hFFFFFF, d1);
		chk("hpf disable", 1'b1, HPF_DISABLE);
		wr(OFS_MISC, 8'h00);
		smp(24'($urandom), d2);
		$display("Test offset hold done");
		wr(OFS_IF_FMT, 8'h95);
		@(posedge CLOCK);
		SYS_RST <= 1'b1;
		rst_chk();
		end_sim();
	end

	// Watchdog
	initial
	begin
		#4000000;
		bad_count++;
		end_sim();
	end
endmodule
